//--- core/tlc_edge_gap.sv
`timescale 1ns/1ps
// synchronises one link clock, finds its edges and spots gaps in it
module tlc_edge_gap
  import tlc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic line_clk,
  output logic rise,
  output logic fall,
  output logic gap
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic seen;
    logic [TLC_CNT_W-1:0] cnt;
    logic [TLC_CNT_W-1:0] last;
    logic rise;
    logic fall;
    logic gap;
  } tlc_eg_t;

  tlc_eg_t st_r;
  tlc_eg_t st_nxt;
  logic [TLC_CNT_W:0] thresh;

  // a gap is a rise-to-rise interval over one and a half normal periods
  always_comb begin
    st_nxt = st_r;
    thresh = {1'b0, st_r.last} + {2'b00, st_r.last[TLC_CNT_W-1:1]};
    st_nxt.s1 = line_clk;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.rise = st_r.s2 & ~st_r.s3;
    st_nxt.fall = ~st_r.s2 & st_r.s3;
    st_nxt.gap = 1'b0;
    if (st_r.s2 & ~st_r.s3) begin
      st_nxt.seen = 1'b1;
      st_nxt.cnt = TLC_CNT_RST;
      // reset to first rise is no clock period, so it is never kept as reference
      if (st_r.seen) begin
        // the first full period has no reference either, so no gap is claimed
        st_nxt.gap = (st_r.last != TLC_CNT_RST) && ({1'b0, st_r.cnt} > thresh);
        st_nxt.last = st_r.cnt;
      end
    end else if (st_r.cnt != TLC_CNT_MAX) begin
      // saturates so a stopped clock reads as one long gap
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise = st_r.rise;
  assign fall = st_r.fall;
  assign gap = st_r.gap;

  a_gap_on_rise: assert property (@(posedge clk) disable iff (!reset_n)
    gap |-> rise) else $error("gap flagged without a clock rise");
endmodule

//--- core/tlc_pkg.sv
// Overview of operation
// - receive test clock output is a buffered copy of the selected receive clock; here it is resampled on CLK and lags three cycles.
// - receive test outputs float whenever the receive test enable is low.
// - transmit links served by fixed priority, link 0 highest, link 31 lowest.
// - each transmit data output changes only on its own clock's falling edge.
// - channelised links find the clock gap and derive time-slot alignment from it.
// - links 3 to 31 accept 50 percent duty clocks from 0 to 10 MHz.
// - links 0 to 2 accept 50 percent duty clocks from 0 to 52 MHz.
// - receive test data updates on the falling edge of the receive test clock.
package tlc_pkg;
  localparam int TLC_LINKS = 32;
  localparam int TLC_SEL_W = 5;
  localparam int TLC_CNT_W = 8;
  // timing figures in their own units
  localparam int TLC_CLK_PERIOD_PS = 5000;
  localparam int TLC_FAST_MAX_MHZ = 52;
  localparam int TLC_SLOW_MAX_MHZ = 10;
  localparam int TLC_FAST_LINKS = 3;
  // shortest half period of a link clock in core cycles, rounded down
  localparam int TLC_FAST_HALF_CYC = (1000000 / (2 * TLC_FAST_MAX_MHZ)) / TLC_CLK_PERIOD_PS;
  localparam int TLC_SLOW_HALF_CYC = (1000000 / (2 * TLC_SLOW_MAX_MHZ)) / TLC_CLK_PERIOD_PS;
  // reset values and counter ceiling
  localparam logic [TLC_LINKS-1:0] TLC_LINK_RST = 32'h0000_0000;
  localparam logic [TLC_CNT_W-1:0] TLC_CNT_RST = 8'h00;
  localparam logic [TLC_CNT_W-1:0] TLC_CNT_MAX = 8'hff;
endpackage

//--- core/tlc_top.sv
`timescale 1ns/1ps
// transmit link clocking front end with receive test clock output
module tlc_top
  import tlc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [TLC_LINKS-1:0] TX_LINE_CLOCK,
  input wire logic [TLC_LINKS-1:0] TX_CHANNELISED,
  input wire logic TX_SERVICE_DATA,
  output logic [TLC_LINKS-1:0] TX_LINE_DATA,
  output logic TX_SERVICE_REQ,
  output logic [TLC_SEL_W-1:0] TX_SERVICE_LINK,
  output logic TX_SERVICE_FRAME_START,
  input wire logic [TLC_LINKS-1:0] RX_LINE_CLOCK,
  input wire logic [TLC_LINKS-1:0] RX_LINE_DATA,
  input wire logic [TLC_SEL_W-1:0] RX_TEST_SELECT,
  input wire logic RX_TEST_OUTPUT_ENABLE,
  output logic RX_TEST_CLOCK_OUT,
  output logic RX_TEST_CLOCK_OE,
  output logic RX_TEST_DATA_OUT,
  output logic RX_TEST_DATA_OE
);
  typedef struct packed {
    logic [TLC_LINKS-1:0] pending;
    logic [TLC_LINKS-1:0] fs_pend;
    logic [TLC_LINKS-1:0] staging;
    logic [TLC_LINKS-1:0] txd;
    logic req;
    logic [TLC_SEL_W-1:0] link;
    logic fs;
    logic [TLC_LINKS-1:0] rxc1;
    logic [TLC_LINKS-1:0] rxc2;
    logic [TLC_LINKS-1:0] rxd1;
    logic [TLC_LINKS-1:0] rxd2;
    logic rclk_out;
    logic rdat;
    logic roe;
  } tlc_st_t;

  tlc_st_t st_r;
  tlc_st_t st_nxt;
  logic [TLC_LINKS-1:0] rise_v;
  logic [TLC_LINKS-1:0] fall_v;
  logic [TLC_LINKS-1:0] gap_v;
  logic found;
  logic [TLC_SEL_W-1:0] win;
  logic rx_clk_sel;
  logic rx_dat_sel;

  // lowest set bit wins, so link 0 always goes first
  function automatic logic [TLC_SEL_W:0] tlc_first_set(input logic [TLC_LINKS-1:0] v);
    logic [TLC_SEL_W:0] r;
    r = '0;
    for (int i = TLC_LINKS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, i[TLC_SEL_W-1:0]};
      end
    end
    return r;
  endfunction

  // picks one link's bit out of a per-link vector
  function automatic logic tlc_bit_at(input logic [TLC_LINKS-1:0] v,
    input logic [TLC_SEL_W-1:0] idx);
    return v[idx];
  endfunction

  // the select mux reads only second-stage flops, never a raw pin
  assign rx_clk_sel = st_r.rxc2[RX_TEST_SELECT];
  assign rx_dat_sel = st_r.rxd2[RX_TEST_SELECT];

  // one synchroniser and gap finder per transmit link clock
  genvar g;
  generate
    for (g = 0; g < TLC_LINKS; g++) begin : g_link
      tlc_edge_gap u_eg (
        .clk(CLK),
        .reset_n(RESET_N),
        .line_clk(TX_LINE_CLOCK[g]),
        .rise(rise_v[g]),
        .fall(fall_v[g]),
        .gap(gap_v[g])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    {found, win} = tlc_first_set(st_r.pending);
    // grant one link per cycle in fixed priority order
    st_nxt.req = found;
    st_nxt.link = win;
    st_nxt.fs = found & st_r.fs_pend[win];
    // a rise asking for the next bit wins over the grant that clears it
    st_nxt.pending = st_r.pending;
    st_nxt.fs_pend = st_r.fs_pend;
    if (found) begin
      st_nxt.pending[win] = 1'b0;
      st_nxt.fs_pend[win] = 1'b0;
    end
    st_nxt.pending = st_nxt.pending | rise_v;
    // the bit after a gap on a channelised link opens the frame
    st_nxt.fs_pend = st_nxt.fs_pend | (rise_v & gap_v & TX_CHANNELISED);
    // the frame engine answers the grant in the same cycle
    if (st_r.req) begin
      st_nxt.staging[st_r.link] = TX_SERVICE_DATA;
    end
    // staged bit reaches the pin only on that link's falling edge
    for (int i = 0; i < TLC_LINKS; i++) begin
      if (fall_v[i]) begin
        st_nxt.txd[i] = st_r.staging[i];
      end
    end
    // every receive pin is synchronised before the mux picks one: more flops,
    // but no line clock or data pin reaches logic unsynchronised
    st_nxt.rxc1 = RX_LINE_CLOCK;
    st_nxt.rxc2 = st_r.rxc1;
    st_nxt.rxd1 = RX_LINE_DATA;
    st_nxt.rxd2 = st_r.rxd1;
    st_nxt.rclk_out = rx_clk_sel;
    // data moves with the falling edge of the copied clock
    if (~rx_clk_sel & st_r.rclk_out) begin
      st_nxt.rdat = rx_dat_sel;
    end
    st_nxt.roe = RX_TEST_OUTPUT_ENABLE;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign TX_LINE_DATA = st_r.txd;
  assign TX_SERVICE_REQ = st_r.req;
  assign TX_SERVICE_LINK = st_r.link;
  assign TX_SERVICE_FRAME_START = st_r.fs;
  assign RX_TEST_CLOCK_OUT = st_r.rclk_out;
  assign RX_TEST_CLOCK_OE = st_r.roe;
  assign RX_TEST_DATA_OUT = st_r.rdat;
  assign RX_TEST_DATA_OE = st_r.roe;

  // receive test pins: a delayed copy of the selected pins, both enables equal
  a_rx_clock_copy: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(rx_clk_sel) |=> RX_TEST_CLOCK_OUT) else $error("test clock did not follow rise");
  a_rx_clock_hiz: assert property (@(posedge CLK) disable iff (!RESET_N)
    !RX_TEST_OUTPUT_ENABLE |=> !RX_TEST_CLOCK_OE) else $error("test clock driven when disabled");
  a_rx_data_hiz: assert property (@(posedge CLK) disable iff (!RESET_N)
    RX_TEST_DATA_OE == RX_TEST_CLOCK_OE) else $error("test data enable differs from clock");
  a_prio_lowest: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_SERVICE_REQ |-> (($past(st_r.pending) & ((32'h1 << TX_SERVICE_LINK) - 32'h1)) == '0))
    else $error("lower numbered link was waiting");
  a_link0_served: assert property (@(posedge CLK) disable iff (!RESET_N)
    rise_v[0] |-> ##2 (TX_SERVICE_REQ && TX_SERVICE_LINK == 5'h00))
    else $error("link 0 not served two cycles after rise");
  a_txd_on_fall: assert property (@(posedge CLK) disable iff (!RESET_N)
    ((TX_LINE_DATA ^ $past(TX_LINE_DATA)) & ~$past(fall_v)) == '0)
    else $error("transmit data moved without a falling edge");
  a_frame_chan: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_SERVICE_FRAME_START |-> TX_SERVICE_REQ && tlc_bit_at($past(st_r.fs_pend), TX_SERVICE_LINK))
    else $error("frame start without a gap on that link");
  a_rx_data_fall: assert property (@(posedge CLK) disable iff (!RESET_N)
    $changed(RX_TEST_DATA_OUT) |-> $fell(RX_TEST_CLOCK_OUT))
    else $error("test data changed off the falling edge");
  a_rx_clock_lag: assert property (@(posedge CLK) disable iff (!RESET_N)
    RX_TEST_CLOCK_OUT == $past(rx_clk_sel))
    else $error("test clock is not the selected clock");
  a_rx_oe_on: assert property (@(posedge CLK) disable iff (!RESET_N)
    RX_TEST_OUTPUT_ENABLE |=> RX_TEST_CLOCK_OE)
    else $error("test clock not driven when enabled");
  a_rx_data_copy: assert property (@(posedge CLK) disable iff (!RESET_N)
    $fell(RX_TEST_CLOCK_OUT) |-> RX_TEST_DATA_OUT == $past(rx_dat_sel))
    else $error("test data is not the selected data");

  // service timing in core cycles: pin rise at c0, rise pulse at c3, pending at c4,
  // grant at c5 with the engine's bit, staged at c6; a fall sends what is staged
  // then, so a link whose high phase is under about three cycles sends each bit
  // one period late. that is why the fast links belong on the low numbers.
  a_grant_pending: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_SERVICE_REQ |-> tlc_bit_at($past(st_r.pending), TX_SERVICE_LINK))
    else $error("grant for a link that was not waiting");
  a_pending_granted: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_r.pending != '0) |=> TX_SERVICE_REQ)
    else $error("waiting link not granted next cycle");
  a_idle_no_grant: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_r.pending == '0) |=> !TX_SERVICE_REQ)
    else $error("grant with no link waiting");
  a_rise_sets_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
    ($past(rise_v) & ~st_r.pending) == '0)
    else $error("clock rise lost before its grant");
  a_grant_clears_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_SERVICE_REQ |-> tlc_bit_at(st_r.pending, TX_SERVICE_LINK) ==
    tlc_bit_at($past(rise_v), TX_SERVICE_LINK))
    else $error("granted link still waiting without a new rise");

  // the granted bit is staged and then leaves only on a falling edge
  a_stage_capture: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_SERVICE_REQ |=> tlc_bit_at(st_r.staging, $past(TX_SERVICE_LINK)) ==
    $past(TX_SERVICE_DATA))
    else $error("service bit not staged for its link");
  a_txd_from_stage: assert property (@(posedge CLK) disable iff (!RESET_N)
    ($past(fall_v) & (TX_LINE_DATA ^ $past(st_r.staging))) == '0)
    else $error("falling edge did not send the staged bit");

  // frame marks come from gaps on channelised links only
  a_fs_after_gap: assert property (@(posedge CLK) disable iff (!RESET_N)
    ($past(rise_v & gap_v & TX_CHANNELISED) & ~st_r.fs_pend) == '0)
    else $error("gap on a channelised link not remembered");
  a_fs_chan_only: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_r.fs_pend & ~$past(st_r.fs_pend) & ~$past(TX_CHANNELISED)) == '0)
    else $error("frame mark raised on an unchannelised link");
  a_frame_granted: assert property (@(posedge CLK) disable iff (!RESET_N)
    TX_SERVICE_REQ |-> TX_SERVICE_FRAME_START ==
    tlc_bit_at($past(st_r.fs_pend), TX_SERVICE_LINK))
    else $error("frame start does not match the waiting mark");
endmodule

//--- verification/tb_tlc_top.sv
`timescale 1ns/1ps
module tb_tlc_top;
  import tlc_pkg::*;
  logic CLK, RESET_N, TX_SERVICE_DATA, RX_TEST_OUTPUT_ENABLE, run, gap_en, clk0, clk5;
  logic [TLC_LINKS-1:0] TX_LINE_CLOCK, TX_CHANNELISED, RX_LINE_CLOCK, RX_LINE_DATA;
  logic [TLC_LINKS-1:0] TX_LINE_DATA;
  logic [TLC_SEL_W-1:0] RX_TEST_SELECT, TX_SERVICE_LINK;
  logic TX_SERVICE_REQ, TX_SERVICE_FRAME_START, RX_TEST_CLOCK_OUT, RX_TEST_CLOCK_OE;
  logic RX_TEST_DATA_OUT, RX_TEST_DATA_OE;
  wire rx_test_clock_out = RX_TEST_CLOCK_OE ? RX_TEST_CLOCK_OUT : 1'bz;
  wire rx_test_data_out = RX_TEST_DATA_OE ? RX_TEST_DATA_OUT : 1'bz;
  int fails, n_tests;
  // fastest source on the top-priority input
  assign TX_LINE_CLOCK = {26'h0, clk5, 4'h0, clk0};
  tlc_src_model #(.HALF_NS(32)) tlc_src_model_inst0 (.run(run), .gap_en(gap_en), .line_clk(clk0));
  tlc_src_model #(.HALF_NS(64)) tlc_src_model_inst5 (.run(run), .gap_en(gap_en), .line_clk(clk5));
  tlc_top tlc_top_inst (.CLK(CLK), .RESET_N(RESET_N), .TX_LINE_CLOCK(TX_LINE_CLOCK),
    .TX_CHANNELISED(TX_CHANNELISED), .TX_SERVICE_DATA(TX_SERVICE_DATA),
    .TX_LINE_DATA(TX_LINE_DATA), .TX_SERVICE_REQ(TX_SERVICE_REQ),
    .TX_SERVICE_LINK(TX_SERVICE_LINK), .TX_SERVICE_FRAME_START(TX_SERVICE_FRAME_START),
    .RX_LINE_CLOCK(RX_LINE_CLOCK), .RX_LINE_DATA(RX_LINE_DATA),
    .RX_TEST_SELECT(RX_TEST_SELECT), .RX_TEST_OUTPUT_ENABLE(RX_TEST_OUTPUT_ENABLE),
    .RX_TEST_CLOCK_OUT(RX_TEST_CLOCK_OUT), .RX_TEST_CLOCK_OE(RX_TEST_CLOCK_OE),
    .RX_TEST_DATA_OUT(RX_TEST_DATA_OUT), .RX_TEST_DATA_OE(RX_TEST_DATA_OE));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // data may only move while its own link clock is low
  always @(TX_LINE_DATA[0]) if (RESET_N === 1'b1) check(clk0, 1'b0, "data 0 moved");
  always @(TX_LINE_DATA[5]) if (RESET_N === 1'b1) check(clk5, 1'b0, "data 5 moved");
  // both links rise together: link 0 first, link 5 right behind
  task automatic prio();
    int i;
    run = 1'b1;
    for (i = 0; i < 400 && TX_SERVICE_REQ !== 1'b1; i++) cyc(1);
    check({TX_SERVICE_REQ, TX_SERVICE_LINK}, 6'h20, "first grant");
    cyc(1);
    check({TX_SERVICE_REQ, TX_SERVICE_LINK}, 6'h25, "second grant");
  endtask
  task automatic data_path();
    TX_SERVICE_DATA = 1'b1;
    cyc(200);
    check({TX_LINE_DATA[5], TX_LINE_DATA[0]}, 2'h3, "ones");
    TX_SERVICE_DATA = 1'b0;
    cyc(200);
    check({TX_LINE_DATA[5], TX_LINE_DATA[0]}, 2'h0, "zeros");
  endtask
  // gapped restart; only the channelised link marks frames, seven bits apart
  task automatic frames();
    int c0, c5, k;
    c0 = 0;
    c5 = 0;
    k = 0;
    run = 1'b0;
    cyc(60);
    TX_CHANNELISED = 32'h0000_0001;
    gap_en = 1'b1;
    run = 1'b1;
    for (int i = 0; i < 2000; i++) begin
      cyc(1);
      if (TX_SERVICE_REQ === 1'b1 && TX_SERVICE_LINK === 5'h00) begin
        if (TX_SERVICE_FRAME_START === 1'b1) begin
          if (c0 > 0) check(k, 7, "slots per frame");
          c0++;
          k = 0;
        end
        k++;
      end
      if (TX_SERVICE_FRAME_START === 1'b1 && TX_SERVICE_LINK === 5'h05) c5++;
    end
    check(c0 > 10, 1'b1, "frames found");
    check(c5, 0, "unchannelised mark");
  endtask
  task automatic rx_test();
    logic d;
    RX_TEST_SELECT = 5'h03;
    RX_TEST_OUTPUT_ENABLE = 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = ~i[0];
      RX_LINE_CLOCK[3] = 1'b1;
      RX_LINE_DATA[3] = d;
      cyc(6);
      check({rx_test_data_out, rx_test_clock_out}, {~d, 1'b1}, "test high");
      RX_LINE_CLOCK[3] = 1'b0;
      cyc(6);
      check({rx_test_data_out, rx_test_clock_out}, {d, 1'b0}, "test low");
    end
    RX_TEST_OUTPUT_ENABLE = 1'b0;
    cyc(3);
    check({rx_test_data_out, rx_test_clock_out}, 2'hz, "test float");
  endtask
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    {RESET_N, TX_SERVICE_DATA, RX_TEST_OUTPUT_ENABLE, run, gap_en} = 5'h0;
    {TX_CHANNELISED, RX_LINE_CLOCK, RX_LINE_DATA} = 96'h0;
    RX_TEST_SELECT = 5'h00;
    fails = 0;
    n_tests = 0;
    cyc(2);
    RESET_N = 1'b1;
    prio();
    data_path();
    frames();
    rx_test();
    results();
  end
endmodule

//--- verification/tlc_src_model.sv
`timescale 1ns/1ps
// framer side: a link clock that idles low and gaps one bit in eight
module tlc_src_model #(
  parameter int HALF_NS = 32
) (
  input wire logic run,
  input wire logic gap_en,
  output logic line_clk
);
  int n;
  // rises only within a run; a stopped clock is legal at any rate
  initial begin
    line_clk = 1'b0;
    n = 0;
    forever begin
      if (!run) begin
        n = 0;
        #1;
      end else begin
        line_clk = !(gap_en && n % 8 == 7);
        #HALF_NS line_clk = 1'b0;
        #HALF_NS n++;
      end
    end
  end
endmodule
